// ==== common/sbi_consts.svh ====
// constants for the system bus pin interface: register offsets, fields, resets
// assumes inclusion by bare name from the bench and the design files
`ifndef SBI_CONSTS_SVH
`define SBI_CONSTS_SVH

`define SBI_OFS_CTRL 12'h000
`define SBI_OFS_TX_DATA 12'h004
`define SBI_OFS_TX_CMD 12'h008
`define SBI_OFS_RX_DATA 12'h00c
`define SBI_OFS_RX_CMD 12'h010
`define SBI_OFS_STATUS 12'h014
`define SBI_OFS_CAUSE 12'h018

`define SBI_CTRL_GO 0
`define SBI_ST_RX_FULL 0
`define SBI_ST_CMD_FAULT 1
`define SBI_ST_CHK_FAULT 2
`define SBI_ST_NMI 3
`define SBI_ST_WARM 4
`define SBI_ST_AGENT_REQ 5
`define SBI_ST_AGENT_RDY 6
`define SBI_ST_BIG_END 8
`define SBI_ST_HALF_RATE 9
`define SBI_ST_PAR_FLOAT 10
`define SBI_CAUSE_INT_LO 10
`define SBI_CAUSE_INT_HI 14

`define SBI_RST_WORD 32'h0000_0000
`define SBI_RST_CMD 5'h00
`define SBI_DIV_FULL 2'h1
`define SBI_DIV_HALF 2'h2
`define SBI_SYNC_W 57
`define SBI_STRAP_AGE 2'h3

`endif

// ==== common/sbi_pkg.sv ====
// types for the system bus pin interface
// assumes sbi_consts.svh is on the include path
package sbi_pkg;
    typedef enum logic [1:0] {
        SBI_IDLE,
        SBI_REQ,
        SBI_DRIVE
    } sbi_state_t;
endpackage

// ==== dv/sbi_agent.sv ====
// external agent model facing the processor pins
// assumes the bench calls send and sets rdy_wait and req_len
`timescale 1ns/1ps
`default_nettype none
module sbi_agent (
    input wire logic clk,
    input wire logic [31:0] addr_data_bus_o,
    input wire logic addr_data_bus_oe,
    input wire logic [3:0] addr_data_check_o,
    input wire logic addr_data_check_oe,
    input wire logic [4:0] cmd_id_bus_o,
    input wire logic cmd_id_bus_oe,
    input wire logic cmd_id_parity_o,
    input wire logic cmd_id_parity_oe,
    input wire logic proc_valid,
    input wire logic proc_request,
    output logic [31:0] addr_data_bus_i,
    output logic [3:0] addr_data_check_i,
    output logic [4:0] cmd_id_bus_i,
    output logic cmd_id_parity_i,
    output logic agent_valid,
    output logic agent_request,
    output logic agent_ready
);
    logic [31:0] ad_q = 32'h0, tx_d;
    logic [3:0] chk_q = 4'h0, tx_k;
    logic [4:0] cmd_q = 5'h0, tx_c;
    logic par_q = 1'b0, tx_p, tx_poe, tx_koe;
    int rdy_wait = 0, req_len = 0, n_tx = 0, wait_q = 0, tx_w = 0;
    // wire level: whoever enables drives
    assign addr_data_bus_i = addr_data_bus_oe ? addr_data_bus_o : ad_q;
    assign addr_data_check_i = addr_data_check_oe ? addr_data_check_o : chk_q;
    assign cmd_id_bus_i = cmd_id_bus_oe ? cmd_id_bus_o : cmd_q;
    assign cmd_id_parity_i = cmd_id_parity_oe ? cmd_id_parity_o : par_q;
    initial begin
        agent_valid = 1'b0;
        agent_request = 1'b0;
        agent_ready = 1'b0;
    end
    always @(posedge clk) begin
        wait_q <= proc_request ? wait_q + 1 : 0;
        // agent wants the bus itself for the first req_len cycles of a request
        agent_request <= proc_request && wait_q < req_len;
        agent_ready <= proc_request && wait_q >= rdy_wait;
        if (proc_valid) begin
            tx_w <= wait_q;
            tx_d <= addr_data_bus_i;
            tx_c <= cmd_id_bus_i;
            tx_k <= addr_data_check_i;
            tx_p <= cmd_id_parity_i;
            tx_koe <= addr_data_check_oe;
            tx_poe <= cmd_id_parity_oe;
            n_tx <= n_tx + 1;
        end
    end
    task automatic send(input logic [31:0] d, input logic [4:0] c, input logic bad);
        @(posedge clk);
        ad_q <= d;
        cmd_q <= c;
        chk_q <= {^d[31:24], ^d[23:16], ^d[15:8], ^d[7:0] ^ bad};
        par_q <= ^c ^ bad;
        repeat (2) @(posedge clk);
        agent_valid <= 1'b1;
        repeat (4) @(posedge clk);
        agent_valid <= 1'b0;
        repeat (4) @(posedge clk);
        // released lines show the inverse
        ad_q <= ~d;
        cmd_q <= ~c;
        chk_q <= ~chk_q;
        par_q <= ~par_q;
    endtask
endmodule
`default_nettype wire

// ==== dv/sbi_asserts.sv ====
// pin-level checks of sbi_top
// assumes straps change only while rst is high
`timescale 1ns/1ps
`default_nettype none
module sbi_asserts (
    input wire logic clk,
    input wire logic rst,
    input wire logic psel,
    input wire logic penable,
    input wire logic [31:0] addr_data_bus_o,
    input wire logic addr_data_bus_oe,
    input wire logic [3:0] addr_data_check_o,
    input wire logic addr_data_check_oe,
    input wire logic [4:0] cmd_id_bus_o,
    input wire logic cmd_id_bus_oe,
    input wire logic cmd_id_parity_o,
    input wire logic cmd_id_parity_oe,
    input wire logic proc_valid,
    input wire logic proc_request,
    input wire logic proc_owns_bus,
    input wire logic fault,
    input wire logic full_init_reset,
    input wire logic ref_clock_in,
    input wire logic ref_clock_echo,
    input wire logic xmit_clock,
    input wire logic half_rate_select,
    input wire logic parity_float_select
);
    logic [2:0] quiet_q;
    logic quiet;
    // cycles since both resets have gone
    always_ff @(posedge clk) begin
        if (rst || full_init_reset) quiet_q <= 3'h0;
        else if (quiet_q != 3'h7) quiet_q <= quiet_q + 3'h1;
    end
    assign quiet = quiet_q > 3'h4;
    default clocking @(posedge clk); endclocking
    default disable iff (rst);
    a_valid_owns_bus: assert property (proc_owns_bus == proc_valid
        && addr_data_bus_oe == proc_valid && cmd_id_bus_oe == proc_valid)
        else $error("valid and ownership disagree");
    a_valid_one_cycle: assert property (proc_valid |=> !proc_valid)
        else $error("valid longer than one cycle");
    a_request_first: assert property ($rose(proc_valid) |-> $past(proc_request)
        && !proc_request) else $error("valid without prior request");
    a_cmd_even_par: assert property (cmd_id_parity_oe |->
        cmd_id_parity_o == ^cmd_id_bus_o) else $error("command parity wrong");
    a_check_lanes: assert property (addr_data_check_oe |->
        addr_data_check_o == {^addr_data_bus_o[31:24], ^addr_data_bus_o[23:16],
        ^addr_data_bus_o[15:8], ^addr_data_bus_o[7:0]}) else $error("check bits wrong");
    a_parity_float: assert property (proc_valid |->
        cmd_id_parity_oe == !parity_float_select && addr_data_check_oe == !parity_float_select)
        else $error("parity enables wrong");
    a_float_no_fault: assert property (quiet && parity_float_select |-> !fault)
        else $error("fault while checking is off");
    a_fault_sticky: assert property (quiet && fault && !(psel && penable) |=> fault)
        else $error("fault dropped by itself");
    a_echo_follows: assert property (quiet |->
        ref_clock_echo == $past(ref_clock_in, 3)) else $error("clock echo lost");
    a_xmit_full: assert property (quiet && !half_rate_select
        |=> $changed(xmit_clock)) else $error("transmit clock not at clk/2");
    a_xmit_half: assert property (quiet && half_rate_select
        && $changed(xmit_clock) |=> $stable(xmit_clock) ##1 $changed(xmit_clock))
        else $error("transmit clock not clk/4");
endmodule
bind sbi_top sbi_asserts i_sbi_asserts (.clk, .rst, .psel, .penable, .addr_data_bus_o,
    .addr_data_bus_oe, .addr_data_check_o, .addr_data_check_oe, .cmd_id_bus_o, .cmd_id_bus_oe,
    .cmd_id_parity_o, .cmd_id_parity_oe, .proc_valid, .proc_request, .proc_owns_bus, .fault,
    .full_init_reset, .ref_clock_in, .ref_clock_echo, .xmit_clock, .half_rate_select,
    .parity_float_select);
`default_nettype wire

// ==== dv/testbench.sv ====
// self-checking bench for sbi_top over apb and the pins
// assumes sbi_agent plays the far side
`timescale 1ns/1ps
`default_nettype none
`include "sbi_consts.svh"
module testbench
    import sbi_pkg::*;
;
    logic clk = 1'b0, rst = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0, pready, pslverr;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0, prdata, addr_data_bus_i, addr_data_bus_o;
    logic [3:0] addr_data_check_i, addr_data_check_o;
    logic [4:0] cmd_id_bus_i, cmd_id_bus_o, int_request = 5'h00;
    logic addr_data_bus_oe, addr_data_check_oe, cmd_id_bus_oe, cmd_id_parity_i;
    logic cmd_id_parity_o, cmd_id_parity_oe, agent_valid, proc_valid, agent_request;
    logic proc_request, proc_owns_bus, agent_ready, fault, ref_clock_echo, xmit_clock;
    logic nmi_request = 1'b0, full_init_reset = 1'b0, warm_reset = 1'b0, ref_clock_in = 1'b0;
    logic byte_order_select = 1'b0, half_rate_select = 1'b0, parity_float_select = 1'b0;
    int mismatches = 0, compares = 0, cyc = 0, n;
    logic [31:0] seed = 32'h50a25108, rd, d, lastd;
    logic [31:0] txq[$];
    logic [4:0] c;
    logic err, bp, pf;
    sbi_top i_sbi_top (.clk, .rst, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
        .pslverr, .addr_data_bus_i, .addr_data_bus_o, .addr_data_bus_oe, .addr_data_check_i,
        .addr_data_check_o, .addr_data_check_oe, .cmd_id_bus_i, .cmd_id_bus_o, .cmd_id_bus_oe,
        .cmd_id_parity_i, .cmd_id_parity_o, .cmd_id_parity_oe, .agent_valid, .proc_valid,
        .agent_request, .proc_request, .proc_owns_bus, .agent_ready, .fault, .int_request,
        .nmi_request, .full_init_reset, .warm_reset, .ref_clock_in, .ref_clock_echo, .xmit_clock,
        .byte_order_select, .half_rate_select, .parity_float_select);
    sbi_agent i_sbi_agent (.clk, .addr_data_bus_o, .addr_data_bus_oe, .addr_data_check_o,
        .addr_data_check_oe, .cmd_id_bus_o, .cmd_id_bus_oe, .cmd_id_parity_o, .cmd_id_parity_oe,
        .proc_valid, .proc_request, .addr_data_bus_i, .addr_data_check_i, .cmd_id_bus_i,
        .cmd_id_parity_i, .agent_valid, .agent_request, .agent_ready);
    initial begin
        forever #10 clk = ~clk;
    end
    initial begin
        #3;
        forever #80 ref_clock_in = ~ref_clock_in;
    end
    task automatic summarize();
        $display("mismatches %0d compares %0d", mismatches, compares);
        if (mismatches == 0 && compares > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask
    always @(posedge clk) begin
        cyc++;
        if (cyc == 5000) begin
            mismatches++;
            summarize();
        end
    end
    task automatic chk(input string nm, input logic [31:0] ex, input logic [31:0] got);
        compares++;
        if (got !== ex) begin
            mismatches++;
            $display("BAD %s exp %h got %h", nm, ex, got);
        end
    endtask
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] wd);
        @(posedge clk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= wd;
        @(posedge clk);
        penable <= 1'b1;
        @(posedge clk);
        while (pready !== 1'b1) @(posedge clk);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    function automatic logic [31:0] sw(input logic [31:0] v);
        return byte_order_select ? {v[7:0], v[15:8], v[23:16], v[31:24]} : v;
    endfunction
    initial begin
        for (int k = 0; k < 4; k++) begin
            rst <= 1'b1;
            byte_order_select <= k[0];
            half_rate_select <= k[1];
            parity_float_select <= k[0] ^ k[1];
            repeat (16) @(posedge clk);
            rst <= 1'b0;
            // straps settle only once the synchroniser has refilled
            repeat (3) @(posedge clk);
            pf = k[0] ^ k[1];
            apb(1'b0, `SBI_OFS_STATUS, 32'h0);
            chk("straps", {21'h0, pf, k[1:0], 8'h00}, rd);
            for (int i = 0; i < 3; i++) begin
                d = $random(seed);
                c = 5'($random(seed));
                lastd = d;
                i_sbi_agent.rdy_wait = i * 6;
                i_sbi_agent.req_len = (i == 1) ? 12 : 0;
                txq.push_back(sw(d));
                apb(1'b1, `SBI_OFS_TX_DATA, d);
                apb(1'b1, `SBI_OFS_TX_CMD, {27'h0, c});
                apb(1'b1, `SBI_OFS_CTRL, 32'h1);
                n = i_sbi_agent.n_tx;
                for (int t = 0; t < 200 && i_sbi_agent.n_tx == n; t++) @(posedge clk);
                d = txq.pop_front();
                chk("tx_data", d, i_sbi_agent.tx_d);
                chk("tx_cmd", c, i_sbi_agent.tx_c);
                chk("tx_oe", {~pf, ~pf}, {i_sbi_agent.tx_koe, i_sbi_agent.tx_poe});
                chk("req_hold", 1'b1, i_sbi_agent.tx_w > i_sbi_agent.req_len);
                if (!pf) chk("tx_par",
                    {^c, ^d[31:24], ^d[23:16], ^d[15:8], ^d[7:0]},
                    {i_sbi_agent.tx_p, i_sbi_agent.tx_k});
            end
            for (int i = 0; i < 3; i++) begin
                d = $random(seed);
                c = 5'($random(seed));
                bp = i == 2 && !pf;
                i_sbi_agent.send(d, c, i == 2);
                apb(1'b0, `SBI_OFS_RX_DATA, 32'h0);
                chk("rx_data", sw(d), rd);
                apb(1'b0, `SBI_OFS_RX_CMD, 32'h0);
                chk("rx_cmd", c, rd);
                apb(1'b1, `SBI_OFS_STATUS, 32'h1);
                apb(1'b0, `SBI_OFS_STATUS, 32'h0);
                chk("rx_flags", {bp, bp, 1'b0}, rd[2:0]);
                chk("fault", bp, fault);
            end
            d = $random(seed);
            int_request <= d[4:0];
            nmi_request <= 1'b1;
            warm_reset <= 1'b1;
            repeat (4) @(posedge clk);
            nmi_request <= 1'b0;
            warm_reset <= 1'b0;
            apb(1'b0, `SBI_OFS_CAUSE, 32'h0);
            chk("cause", {17'h0, d[4:0], 10'h0}, rd);
            apb(1'b0, `SBI_OFS_STATUS, 32'h0);
            chk("events", 2'b11, rd[4:3]);
            apb(1'b0, `SBI_OFS_TX_DATA, 32'h0);
            chk("kept", lastd, rd);
            apb(1'b0, 12'h01c, 32'h0);
            chk("unmapped", 32'h1, {rd[30:0], err});
            full_init_reset <= 1'b1;
            repeat (4) @(posedge clk);
            full_init_reset <= 1'b0;
            repeat (6) @(posedge clk);
            chk("fault_clr", 1'b0, fault);
            apb(1'b0, `SBI_OFS_TX_DATA, 32'h0);
            chk("tx_clr", 32'h0, rd);
        end
        summarize();
    end
endmodule
`default_nettype wire

// ==== hw/sbi_sync.sv ====
// two flip-flop synchroniser, one per bit
// assumes every input bit is asynchronous to clk
`timescale 1ns/1ps
`default_nettype none
module sbi_sync #(
    parameter int W = 1
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic [W-1:0] d,
    output logic [W-1:0] q
);
    logic [W-1:0] meta_q;
    logic [W-1:0] meta_d;
    logic [W-1:0] q_d;

    genvar i;
    generate
        for (i = 0; i < W; i++) begin : g_bit
            always_comb begin
                meta_d[i] = d[i];
                q_d[i] = meta_q[i];
            end
        end
    endgenerate

    always_ff @(posedge clk) begin
        if (rst) begin
            meta_q <= '0;
            q <= '0;
        end else begin
            meta_q <= meta_d;
            q <= q_d;
        end
    end
endmodule
`default_nettype wire

// ==== hw/sbi_top.sv ====
// processor-side system bus pin interface with an apb register port
// assumes clk is the pipeline clock; every pin input is asynchronous to it
`timescale 1ns/1ps
`default_nettype none
`include "sbi_consts.svh"

// What this block does
// - 32-bit shared address/data bus, driven out or sampled in
// - 4-bit check bus travels with the address/data bus
// - 5-bit command/identifier bus in both directions
// - one parity line with even parity over the five command bits
// - processor valid only while driving valid address/data and command
// - processor request raised while it needs to issue
// - bus-ownership output high while the processor controls the bus
// - fault output on a command parity error
// - five interrupt inputs shown in cause bits 14 to 10
// - non-maskable interrupt input, no mask blocks it
// - full-initialization reset clears all internal state except the pin synchroniser flops, which only rst clears
// - warm reset raises a reset exception, state kept
// - clock echo output reproduces the reference clock
// - transmit clock output times the system interface
// - byte-order strap sampled at cold reset selects endian mode
// - rate-select strap chooses the transmit clock divisor
// - parity-float strap floats parity outputs and stops checking
// - pipeline clock runs at four times the reference clock; the bench runs clk at eight times
// - transmit clock runs at the divided interface clock rate
module sbi_top
    import sbi_pkg::*;
(
    input wire logic clk,
    input wire logic rst,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic [31:0] addr_data_bus_i,
    output logic [31:0] addr_data_bus_o,
    output logic addr_data_bus_oe,
    input wire logic [3:0] addr_data_check_i,
    output logic [3:0] addr_data_check_o,
    output logic addr_data_check_oe,
    input wire logic [4:0] cmd_id_bus_i,
    output logic [4:0] cmd_id_bus_o,
    output logic cmd_id_bus_oe,
    input wire logic cmd_id_parity_i,
    output logic cmd_id_parity_o,
    output logic cmd_id_parity_oe,
    input wire logic agent_valid,
    output logic proc_valid,
    input wire logic agent_request,
    output logic proc_request,
    output logic proc_owns_bus,
    input wire logic agent_ready,
    output logic fault,
    input wire logic [4:0] int_request,
    input wire logic nmi_request,
    input wire logic full_init_reset,
    input wire logic warm_reset,
    input wire logic ref_clock_in,
    output logic ref_clock_echo,
    output logic xmit_clock,
    input wire logic byte_order_select,
    input wire logic half_rate_select,
    input wire logic parity_float_select
);
    logic [`SBI_SYNC_W-1:0] raw;
    logic [`SBI_SYNC_W-1:0] syn;
    logic valid_s, req_s, rdy_s, par_s, nmi_s, warm_s, init_s, ref_s;
    logic big_s, half_s, float_s;
    logic [4:0] cmd_s;
    logic [4:0] int_s;
    logic [31:0] data_s;
    logic [3:0] chk_s;
    logic init;

    // every pin input passes two flops before use
    assign raw = {agent_valid, agent_request, agent_ready, cmd_id_parity_i, cmd_id_bus_i,
                  addr_data_bus_i, addr_data_check_i, int_request, nmi_request, warm_reset,
                  full_init_reset, ref_clock_in, byte_order_select, half_rate_select,
                  parity_float_select};

    sbi_sync #(.W(`SBI_SYNC_W)) u_sync (
        .clk(clk),
        .rst(rst),
        .d(raw),
        .q(syn)
    );

    assign {valid_s, req_s, rdy_s, par_s, cmd_s, data_s, chk_s, int_s, nmi_s, warm_s,
            init_s, ref_s, big_s, half_s, float_s} = syn;

    assign init = rst | init_s;

    // straps, loaded until the synchroniser has refilled after a reset, then frozen
    logic [1:0] strap_age_q, strap_age_d;
    logic big_q, big_d, half_q, half_d, float_q, float_d;

    always_comb begin
        strap_age_d = strap_age_q;
        big_d = big_q;
        half_d = half_q;
        float_d = float_q;
        if (strap_age_q != `SBI_STRAP_AGE) begin
            strap_age_d = strap_age_q + 2'h1;
            big_d = big_s;
            half_d = half_s;
            float_d = float_s;
        end
    end

    always_ff @(posedge clk) begin
        if (init) begin
            strap_age_q <= 2'h0;
            big_q <= 1'b0;
            half_q <= 1'b0;
            float_q <= 1'b0;
        end else begin
            strap_age_q <= strap_age_d;
            big_q <= big_d;
            half_q <= half_d;
            float_q <= float_d;
        end
    end

    // clock outputs; clk stands in for the pipeline clock, 8x the reference in the bench
    logic echo_q, echo_d, xclk_q, xclk_d;
    logic [1:0] div_cnt_q, div_cnt_d;
    logic [1:0] div;

    always_comb begin
        div = half_q ? `SBI_DIV_HALF : `SBI_DIV_FULL;
        echo_d = ref_s;
        div_cnt_d = div_cnt_q + 2'h1;
        xclk_d = xclk_q;
        if (div_cnt_d >= div) begin
            div_cnt_d = 2'h0;
            xclk_d = ~xclk_q;
        end
    end

    always_ff @(posedge clk) begin
        if (init) begin
            echo_q <= 1'b0;
            xclk_q <= 1'b0;
            div_cnt_q <= 2'h0;
        end else begin
            echo_q <= echo_d;
            xclk_q <= xclk_d;
            div_cnt_q <= div_cnt_d;
        end
    end

    assign ref_clock_echo = echo_q;
    assign xmit_clock = xclk_q;

    // apb decode
    logic setup, wr_acc;
    assign setup = psel & ~penable;
    assign wr_acc = psel & penable & pwrite;
    assign pready = 1'b1;

    logic mapped;
    always_comb begin
        unique case (paddr)
            `SBI_OFS_CTRL, `SBI_OFS_TX_DATA, `SBI_OFS_TX_CMD, `SBI_OFS_RX_DATA,
            `SBI_OFS_RX_CMD, `SBI_OFS_STATUS, `SBI_OFS_CAUSE: mapped = 1'b1;
            default: mapped = 1'b0;
        endcase
    end
    assign pslverr = psel & penable & ~mapped;

    // issue sequencer and link registers
    sbi_state_t st_q, st_d;
    logic [31:0] tx_data_q, tx_data_d, rx_data_q, rx_data_d;
    logic [4:0] tx_cmd_q, tx_cmd_d, rx_cmd_q, rx_cmd_d;
    logic [31:0] out_q, out_d;
    logic [3:0] out_chk_q, out_chk_d;
    logic [4:0] out_cmd_q, out_cmd_d;
    logic out_par_q, out_par_d;
    logic valid_prev_q, nmi_prev_q, warm_prev_q;
    logic rx_full_q, rx_full_d, cmd_flt_q, cmd_flt_d, chk_flt_q, chk_flt_d;
    logic nmi_q, nmi_d, warm_q, warm_d;
    logic [31:0] prdata_q, prdata_d;
    logic [31:0] tx_swap, rx_swap;
    logic [3:0] rx_lane_par, tx_lane_par;
    logic rx_word, clr;

    assign tx_swap = big_q ? {tx_data_q[7:0], tx_data_q[15:8], tx_data_q[23:16],
                              tx_data_q[31:24]} : tx_data_q;
    assign rx_swap = big_q ? {data_s[7:0], data_s[15:8], data_s[23:16], data_s[31:24]}
                           : data_s;

    genvar g;
    generate
        for (g = 0; g < 4; g++) begin : g_lane
            assign tx_lane_par[g] = ^tx_swap[8*g +: 8];
            assign rx_lane_par[g] = ^data_s[8*g +: 8];
        end
    endgenerate

    // a word arrives on the rising edge of the agent's valid, bus not ours
    assign rx_word = valid_s & ~valid_prev_q & (st_q != SBI_DRIVE);
    assign clr = wr_acc & (paddr == `SBI_OFS_STATUS);

    always_comb begin
        st_d = st_q;
        tx_data_d = tx_data_q;
        tx_cmd_d = tx_cmd_q;
        out_d = out_q;
        out_chk_d = out_chk_q;
        out_cmd_d = out_cmd_q;
        out_par_d = out_par_q;
        if (wr_acc && paddr == `SBI_OFS_TX_DATA) begin
            tx_data_d = pwdata;
        end
        if (wr_acc && paddr == `SBI_OFS_TX_CMD) begin
            tx_cmd_d = pwdata[4:0];
        end
        unique case (st_q)
            SBI_IDLE: begin
                if (wr_acc && paddr == `SBI_OFS_CTRL && pwdata[`SBI_CTRL_GO]) begin
                    st_d = SBI_REQ;
                end
            end
            SBI_REQ: begin
                // wait for the agent to be ready and not asking for itself
                if (rdy_s && !req_s) begin
                    st_d = SBI_DRIVE;
                    out_d = tx_swap;
                    out_chk_d = tx_lane_par;
                    out_cmd_d = tx_cmd_q;
                    out_par_d = ^tx_cmd_q;
                end
            end
            SBI_DRIVE: begin
                st_d = SBI_IDLE;
            end
        endcase
    end

    always_comb begin
        rx_data_d = rx_data_q;
        rx_cmd_d = rx_cmd_q;
        rx_full_d = rx_full_q;
        cmd_flt_d = cmd_flt_q;
        chk_flt_d = chk_flt_q;
        nmi_d = nmi_q;
        warm_d = warm_q;
        // write-one-to-clear first, so a same-cycle event still sets
        if (clr) begin
            rx_full_d = rx_full_q & ~pwdata[`SBI_ST_RX_FULL];
            cmd_flt_d = cmd_flt_q & ~pwdata[`SBI_ST_CMD_FAULT];
            chk_flt_d = chk_flt_q & ~pwdata[`SBI_ST_CHK_FAULT];
            nmi_d = nmi_q & ~pwdata[`SBI_ST_NMI];
            warm_d = warm_q & ~pwdata[`SBI_ST_WARM];
        end
        if (rx_word) begin
            rx_data_d = rx_swap;
            rx_cmd_d = cmd_s;
            rx_full_d = 1'b1;
            if (!float_q && (par_s != ^cmd_s)) begin
                cmd_flt_d = 1'b1;
            end
            if (!float_q && (chk_s != rx_lane_par)) begin
                chk_flt_d = 1'b1;
            end
        end
        if (nmi_s && !nmi_prev_q) begin
            nmi_d = 1'b1;
        end
        if (warm_s && !warm_prev_q) begin
            warm_d = 1'b1;
        end
    end

    always_comb begin
        prdata_d = prdata_q;
        if (setup) begin
            prdata_d = `SBI_RST_WORD;
            unique case (paddr)
                `SBI_OFS_CTRL: prdata_d[`SBI_CTRL_GO] = (st_q != SBI_IDLE);
                `SBI_OFS_TX_DATA: prdata_d = tx_data_q;
                `SBI_OFS_TX_CMD: prdata_d[4:0] = tx_cmd_q;
                `SBI_OFS_RX_DATA: prdata_d = rx_data_q;
                `SBI_OFS_RX_CMD: prdata_d[4:0] = rx_cmd_q;
                `SBI_OFS_STATUS: begin
                    prdata_d[`SBI_ST_RX_FULL] = rx_full_q;
                    prdata_d[`SBI_ST_CMD_FAULT] = cmd_flt_q;
                    prdata_d[`SBI_ST_CHK_FAULT] = chk_flt_q;
                    prdata_d[`SBI_ST_NMI] = nmi_q;
                    prdata_d[`SBI_ST_WARM] = warm_q;
                    prdata_d[`SBI_ST_AGENT_REQ] = req_s;
                    prdata_d[`SBI_ST_AGENT_RDY] = rdy_s;
                    prdata_d[`SBI_ST_BIG_END] = big_q;
                    prdata_d[`SBI_ST_HALF_RATE] = half_q;
                    prdata_d[`SBI_ST_PAR_FLOAT] = float_q;
                end
                `SBI_OFS_CAUSE: prdata_d[`SBI_CAUSE_INT_HI:`SBI_CAUSE_INT_LO] = int_s;
                default: prdata_d = `SBI_RST_WORD;
            endcase
        end
    end

    // warm reset keeps everything; only rst or full init clears state
    always_ff @(posedge clk) begin
        if (init) begin
            st_q <= SBI_IDLE;
            tx_data_q <= `SBI_RST_WORD;
            tx_cmd_q <= `SBI_RST_CMD;
            rx_data_q <= `SBI_RST_WORD;
            rx_cmd_q <= `SBI_RST_CMD;
            out_q <= `SBI_RST_WORD;
            out_chk_q <= 4'h0;
            out_cmd_q <= `SBI_RST_CMD;
            out_par_q <= 1'b0;
            valid_prev_q <= 1'b0;
            nmi_prev_q <= 1'b0;
            warm_prev_q <= 1'b0;
            rx_full_q <= 1'b0;
            cmd_flt_q <= 1'b0;
            chk_flt_q <= 1'b0;
            nmi_q <= 1'b0;
            warm_q <= 1'b0;
            prdata_q <= `SBI_RST_WORD;
        end else begin
            st_q <= st_d;
            tx_data_q <= tx_data_d;
            tx_cmd_q <= tx_cmd_d;
            rx_data_q <= rx_data_d;
            rx_cmd_q <= rx_cmd_d;
            out_q <= out_d;
            out_chk_q <= out_chk_d;
            out_cmd_q <= out_cmd_d;
            out_par_q <= out_par_d;
            valid_prev_q <= valid_s;
            nmi_prev_q <= nmi_s;
            warm_prev_q <= warm_s;
            rx_full_q <= rx_full_d;
            cmd_flt_q <= cmd_flt_d;
            chk_flt_q <= chk_flt_d;
            nmi_q <= nmi_d;
            warm_q <= warm_d;
            prdata_q <= prdata_d;
        end
    end

    assign prdata = prdata_q;
    assign proc_request = (st_q == SBI_REQ);
    assign proc_owns_bus = (st_q == SBI_DRIVE);
    assign proc_valid = (st_q == SBI_DRIVE);
    assign addr_data_bus_o = out_q;
    assign addr_data_bus_oe = (st_q == SBI_DRIVE);
    assign cmd_id_bus_o = out_cmd_q;
    assign cmd_id_bus_oe = (st_q == SBI_DRIVE);
    assign addr_data_check_o = out_chk_q;
    assign addr_data_check_oe = (st_q == SBI_DRIVE) & ~float_q;
    assign cmd_id_parity_o = out_par_q;
    assign cmd_id_parity_oe = (st_q == SBI_DRIVE) & ~float_q;
    assign fault = cmd_flt_q;
endmodule
`default_nettype wire
